// ### core/led_i2c_slave.sv
`timescale 1ns/100ps
module led_i2c_slave #(
  parameter logic [2:0] REV_CODE  = 3'h1, // arbitrary value
  parameter int         SPIKE_CYC = led_if_pkg::SPIKE_CYC
) (
  input  wire logic       CLOCK,
  input  wire logic       RSTN,
  input  wire logic       CE,
  input  wire logic       SCL_CLK,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       BUSY,
  input  wire logic       ADC_VALID,
  input  wire logic [2:0] ADC_CHAN,
  input  wire logic [7:0] ADC_DATA,
  input  wire logic [3:0] SHORT_FAULT,
  input  wire logic       OV_FAULT,
  output logic      [6:0] STRING1_CODE,
  output logic      [6:0] STRING2_CODE,
  output logic      [6:0] STRING3_CODE,
  output logic      [6:0] STRING4_CODE,
  output logic      [6:0] REGULATOR_CODE,
  output logic            LOW_POWER_STANDBY
);

  typedef struct packed {
    logic [led_if_pkg::PTR_W-1:0]                    ptr;
    logic [3:0][led_if_pkg::CODE_W-1:0]              str_code;
    logic [led_if_pkg::CODE_W-1:0]                   reg_code;
    logic [led_if_pkg::NUM_READ-1:0][7:0]            reading;
    logic [led_if_pkg::FAULT_W-1:0]                  fault;
    logic                                            standby;
    logic [7:0]                                      rd_byte;
    logic                                            ev_s1;
    logic                                            ev_s2;
    logic                                            ev_s3;
    logic                                            busy;
    logic                                            sda_prev;
    logic                                            frame_rst_n;
  } sys_t;

  typedef struct packed {
    led_if_pkg::link_state_t state;
    logic [3:0]              cnt;
    logic [7:0]              shift;
    logic                    ack_want;
    logic [7:0]              tx;
    logic                    ev_tog;
    led_if_pkg::ev_kind_t    ev_kind;
    logic [7:0]              ev_data;
    logic                    busy_s1;
    logic                    busy_s2;
  } link_t;

  typedef struct packed {
    logic oe;
    logic out;
  } drv_t;

  sys_t  s_reg;
  sys_t  s_next;
  link_t lk_reg;
  link_t lk_next;
  drv_t  d_reg;
  drv_t  d_next;

  logic                                 scl_f;
  logic                                 sda_f;
  logic [4:0]                           flt_f;
  logic                                 ev_fire;
  logic                                 start_cond;
  logic                                 stop_cond;
  logic                                 fault_clr;
  logic [led_if_pkg::FAULT_W-1:0]       fault_set;
  logic [7:0]                           byte_in;

  // next pointer with wrap from last location to first
  function automatic logic [led_if_pkg::PTR_W-1:0] next_ptr(
    input logic [led_if_pkg::PTR_W-1:0] p
  );
    if (p == led_if_pkg::IDX_LAST) begin
      next_ptr = led_if_pkg::IDX_FIRST;
    end else begin
      next_ptr = p + 1'b1;
    end
  endfunction

  // read mux of the register map
  function automatic logic [7:0] reg_read(
    input sys_t                         st,
    input logic [led_if_pkg::PTR_W-1:0] p
  );
    if (p <= led_if_pkg::IDX_STR4) begin
      reg_read = 8'(st.str_code[p[led_if_pkg::STR_SEL_W-1:0]]);
    end else if (p == led_if_pkg::IDX_REG_OUT) begin
      reg_read = 8'(st.reg_code);
    end else if (p <= led_if_pkg::IDX_RD_OUT) begin
      reg_read = st.reading[3'(p - led_if_pkg::IDX_RD1)];
    end else if (p == led_if_pkg::IDX_FAULT) begin
      reg_read = 8'(st.fault);
    end else if (p == led_if_pkg::IDX_STANDBY) begin
      reg_read = 8'(st.standby);
    end else if (p == led_if_pkg::IDX_REV) begin
      reg_read = 8'(REV_CODE);
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  // spike filters on both bus lines
  line_filter #(
    .WIDTH  (2),
    .STABLE (SPIKE_CYC),
    .INIT   (2'b11)
  ) u_bus_filt (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .ce    (CE),
    .din   ({SCL_CLK, SDA_IN}),
    .dout  ({scl_f, sda_f})
  );

  // fault comparators must stay active longer than one cycle
  line_filter #(
    .WIDTH  (5),
    .STABLE (led_if_pkg::FAULT_MIN_CYC),
    .INIT   (5'h00)
  ) u_fault_filt (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .ce    (CE),
    .din   ({SHORT_FAULT, OV_FAULT}),
    .dout  (flt_f)
  );

  // system clock side: conditions, register file, pointer
  always_comb begin
    s_next          = s_reg;
    s_next.ev_s1    = lk_reg.ev_tog;
    s_next.ev_s2    = s_reg.ev_s1;
    s_next.ev_s3    = s_reg.ev_s2;
    s_next.busy     = BUSY;
    s_next.sda_prev = sda_f;
    ev_fire         = s_reg.ev_s2 ^ s_reg.ev_s3;
    // frame reset forces the link toggle low; drop stale copies so no false event
    if (!s_reg.frame_rst_n) begin
      s_next.ev_s1 = 1'b0;
      s_next.ev_s2 = 1'b0;
      s_next.ev_s3 = 1'b0;
    end
    start_cond      = scl_f & s_reg.sda_prev & ~sda_f;
    stop_cond       = scl_f & ~s_reg.sda_prev & sda_f;
    fault_clr       = 1'b0;
    fault_set       = '0;
    fault_set[led_if_pkg::FAULT_OV_BIT] = flt_f[0];
    fault_set[led_if_pkg::FAULT_SH_LSB +: 4] = flt_f[4:1];

    if (start_cond || stop_cond) begin
      s_next.frame_rst_n = 1'b0;
    end else if (!scl_f) begin
      s_next.frame_rst_n = 1'b1;
    end

    if (ADC_VALID && (ADC_CHAN <= led_if_pkg::OUT_CHAN)) begin
      s_next.reading[ADC_CHAN] = ADC_DATA;
      if (ADC_CHAN == led_if_pkg::OUT_CHAN) begin
        s_next.reading[ADC_CHAN][led_if_pkg::TIMEOUT_BIT] = 1'b0;
      end
    end

    if (ev_fire) begin
      unique case (lk_reg.ev_kind)
        led_if_pkg::EV_CMD: begin
          s_next.ptr = lk_reg.ev_data[led_if_pkg::PTR_W-1:0];
        end
        led_if_pkg::EV_WR: begin
          if (s_reg.ptr <= led_if_pkg::IDX_STR4) begin
            s_next.str_code[s_reg.ptr[led_if_pkg::STR_SEL_W-1:0]] =
              lk_reg.ev_data[led_if_pkg::CODE_W-1:0];
          end else if (s_reg.ptr == led_if_pkg::IDX_REG_OUT) begin
            s_next.reg_code = lk_reg.ev_data[led_if_pkg::CODE_W-1:0];
          end else if (s_reg.ptr == led_if_pkg::IDX_STANDBY) begin
            s_next.standby = lk_reg.ev_data[led_if_pkg::STANDBY_BIT];
            fault_clr = lk_reg.ev_data[led_if_pkg::STANDBY_BIT] & ~s_reg.standby;
          end
          s_next.ptr = next_ptr(s_reg.ptr);
        end
        led_if_pkg::EV_RD: begin
          fault_clr  = (s_reg.ptr == led_if_pkg::IDX_FAULT);
          s_next.ptr = next_ptr(s_reg.ptr);
        end
        default: begin
        end
      endcase
    end

    // clear first, so a fault arriving in the same cycle survives
    if (fault_clr) begin
      s_next.fault = '0;
    end
    if (!s_reg.standby) begin
      s_next.fault = s_next.fault | fault_set;
    end
    s_next.rd_byte = reg_read(s_reg, s_reg.ptr);
  end

  // system clock register
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s_reg <= '{
        ptr: led_if_pkg::IDX_FIRST,
        str_code: {4{led_if_pkg::CODE_RESET}},
        reg_code: led_if_pkg::CODE_RESET,
        sda_prev: 1'b1,
        default: '0
      };
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // link side, bits sampled on the rising bus clock
  always_comb begin
    lk_next         = lk_reg;
    lk_next.busy_s1 = s_reg.busy;
    lk_next.busy_s2 = lk_reg.busy_s1;
    byte_in         = {lk_reg.shift[6:0], SDA_IN};
    if (lk_reg.cnt == led_if_pkg::ACK_SLOT) begin
      lk_next.cnt      = '0;
      lk_next.ack_want = 1'b0;
      if (lk_reg.state == led_if_pkg::LS_RDATA) begin
        if (SDA_IN) begin
          lk_next.state = led_if_pkg::LS_IGNORE;
        end else begin
          lk_next.tx = s_reg.rd_byte;
        end
      end
    end else begin
      lk_next.shift = byte_in;
      lk_next.cnt   = lk_reg.cnt + 1'b1;
      if (lk_reg.cnt == led_if_pkg::LAST_DATA_BIT) begin
        unique case (lk_reg.state)
          led_if_pkg::LS_ADDR: begin
            if (byte_in[7:1] == led_if_pkg::SLAVE_ADDR) begin
              lk_next.ack_want = 1'b1;
              lk_next.state = byte_in[led_if_pkg::RW_BIT] ?
                led_if_pkg::LS_RDATA : led_if_pkg::LS_CMD;
            end else begin
              lk_next.state = led_if_pkg::LS_IGNORE;
            end
          end
          led_if_pkg::LS_CMD: begin
            if ((byte_in <= 8'(led_if_pkg::IDX_LAST)) && !lk_reg.busy_s2) begin
              lk_next.ack_want = 1'b1;
              lk_next.state    = led_if_pkg::LS_WDATA;
              lk_next.ev_tog   = ~lk_reg.ev_tog;
              lk_next.ev_kind  = led_if_pkg::EV_CMD;
              lk_next.ev_data  = byte_in;
            end else begin
              lk_next.state = led_if_pkg::LS_IGNORE;
            end
          end
          led_if_pkg::LS_WDATA: begin
            lk_next.ack_want = 1'b1;
            lk_next.ev_tog   = ~lk_reg.ev_tog;
            lk_next.ev_kind  = led_if_pkg::EV_WR;
            lk_next.ev_data  = byte_in;
          end
          led_if_pkg::LS_RDATA: begin
            lk_next.ev_tog  = ~lk_reg.ev_tog;
            lk_next.ev_kind = led_if_pkg::EV_RD;
          end
          led_if_pkg::LS_IGNORE: begin
          end
          default: begin
            lk_next.state = led_if_pkg::LS_IGNORE;
          end
        endcase
      end
    end
  end

  // link register, cleared by reset or by each start and stop
  always_ff @(posedge SCL_CLK or negedge s_reg.frame_rst_n) begin
    if (!s_reg.frame_rst_n) begin
      lk_reg <= '{
        state: led_if_pkg::LS_ADDR,
        ev_kind: led_if_pkg::EV_CMD,
        default: '0
      };
    end else begin
      lk_reg <= lk_next;
    end
  end

  // data line drive, changed on the falling bus clock or released at once by frame reset
  always_comb begin
    d_next.out = 1'b0;
    if (lk_reg.cnt == led_if_pkg::ACK_SLOT) begin
      d_next.oe = lk_reg.ack_want;
    end else if (lk_reg.state == led_if_pkg::LS_RDATA) begin
      d_next.oe = ~lk_reg.tx[3'(led_if_pkg::LAST_DATA_BIT - lk_reg.cnt)];
    end else begin
      d_next.oe = 1'b0;
    end
  end

  // open-drain driver; the clock line has no driver at all
  always_ff @(negedge SCL_CLK or negedge s_reg.frame_rst_n) begin
    if (!s_reg.frame_rst_n) begin
      d_reg <= '{oe: 1'b0, out: 1'b0};
    end else begin
      d_reg <= d_next;
    end
  end

  // outputs straight from the registers
  assign SDA_OE            = d_reg.oe;
  assign SDA_OUT           = d_reg.out;
  assign STRING1_CODE      = s_reg.str_code[0];
  assign STRING2_CODE      = s_reg.str_code[1];
  assign STRING3_CODE      = s_reg.str_code[2];
  assign STRING4_CODE      = s_reg.str_code[3];
  assign REGULATOR_CODE    = s_reg.reg_code;
  assign LOW_POWER_STANDBY = s_reg.standby;

  property p_ptr_wrap;
    @(posedge CLOCK) disable iff (!RSTN)
      (CE && ev_fire && lk_reg.ev_kind != led_if_pkg::EV_CMD
       && s_reg.ptr == led_if_pkg::IDX_LAST) |=> (s_reg.ptr == led_if_pkg::IDX_FIRST);
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer missed wrap");

  property p_ptr_step;
    @(posedge CLOCK) disable iff (!RSTN)
      (CE && ev_fire && lk_reg.ev_kind == led_if_pkg::EV_RD
       && s_reg.ptr < led_if_pkg::IDX_LAST) |=> (s_reg.ptr == $past(s_reg.ptr) + 1'b1);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer missed step");

  property p_cmd_load;
    @(posedge CLOCK) disable iff (!RSTN)
      (CE && ev_fire && lk_reg.ev_kind == led_if_pkg::EV_CMD)
      |=> (s_reg.ptr == $past(lk_reg.ev_data[3:0]));
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("command not loaded");

  property p_str_write;
    @(posedge CLOCK) disable iff (!RSTN)
      (CE && ev_fire && lk_reg.ev_kind == led_if_pkg::EV_WR
       && s_reg.ptr == led_if_pkg::IDX_FIRST) |=> (STRING1_CODE == $past(lk_reg.ev_data[6:0]));
  endproperty
  a_str_write: assert property (p_str_write) else $error("string code lost");

  property p_standby;
    @(posedge CLOCK) disable iff (!RSTN)
      (CE && ev_fire && lk_reg.ev_kind == led_if_pkg::EV_WR
       && s_reg.ptr == led_if_pkg::IDX_STANDBY) |=> (LOW_POWER_STANDBY == $past(lk_reg.ev_data[0]));
  endproperty
  a_standby: assert property (p_standby) else $error("standby not taken");

  property p_fault_log;
    @(posedge CLOCK) disable iff (!RSTN)
      (CE && !s_reg.standby && flt_f[0]) |=> s_reg.fault[led_if_pkg::FAULT_OV_BIT];
  endproperty
  a_fault_log: assert property (p_fault_log) else $error("fault not logged");

  property p_fault_clear;
    @(posedge CLOCK) disable iff (!RSTN)
      (CE && ev_fire && lk_reg.ev_kind == led_if_pkg::EV_RD
       && s_reg.ptr == led_if_pkg::IDX_FAULT && fault_set == '0) |=> (s_reg.fault == '0);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

  property p_ro_keep;
    @(posedge CLOCK) disable iff (!RSTN)
      (CE && ev_fire && lk_reg.ev_kind == led_if_pkg::EV_WR && !ADC_VALID
       && s_reg.ptr >= led_if_pkg::IDX_RD1 && s_reg.ptr <= led_if_pkg::IDX_RD_OUT)
      |=> $stable(s_reg.reading);
  endproperty
  a_ro_keep: assert property (p_ro_keep) else $error("read-only changed");

  property p_idle_release;
    @(posedge CLOCK) disable iff (!RSTN)
      (!s_reg.frame_rst_n) [*2] |-> !SDA_OE;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("data held idle");

  property p_addr_ack;
    @(posedge SCL_CLK) disable iff (!s_reg.frame_rst_n)
      (lk_reg.cnt == led_if_pkg::LAST_DATA_BIT && lk_reg.state == led_if_pkg::LS_ADDR
       && lk_reg.shift[6:0] == led_if_pkg::SLAVE_ADDR) |=> (SDA_OE && !SDA_OUT);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

  property p_bad_cmd;
    @(posedge SCL_CLK) disable iff (!s_reg.frame_rst_n)
      (lk_reg.cnt == led_if_pkg::LAST_DATA_BIT && lk_reg.state == led_if_pkg::LS_CMD
       && byte_in > 8'(led_if_pkg::IDX_LAST)) |=> (!SDA_OE && $stable(lk_reg.ev_tog));
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command acked");

  property p_tx_bit;
    @(posedge SCL_CLK) disable iff (!s_reg.frame_rst_n)
      (lk_reg.state == led_if_pkg::LS_RDATA && lk_reg.cnt < led_if_pkg::ACK_SLOT)
      |-> (SDA_OE == ~lk_reg.tx[3'(led_if_pkg::LAST_DATA_BIT - lk_reg.cnt)]);
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("read bit wrong");

endmodule

// ### core/led_if_pkg.sv
package led_if_pkg;

  localparam logic [6:0] SLAVE_ADDR    = 7'h58;
  localparam logic [7:0] ADDR_BYTE_WR  = 8'hB0;
  localparam logic [7:0] ADDR_BYTE_RD  = 8'hB1;

  localparam int         PTR_W         = 4;
  localparam int         STR_SEL_W     = 2;
  localparam int         CODE_W        = 7;
  localparam int         FAULT_W       = 6;
  localparam int         REV_W         = 3;
  localparam int         NUM_READ      = 5;
  localparam logic [3:0] IDX_FIRST     = 4'h0;
  localparam logic [3:0] IDX_STR4      = 4'h3;
  localparam logic [3:0] IDX_REG_OUT   = 4'h4;
  localparam logic [3:0] IDX_RD1       = 4'h5;
  localparam logic [3:0] IDX_RD_OUT    = 4'h9;
  localparam logic [3:0] IDX_FAULT     = 4'hA;
  localparam logic [3:0] IDX_STANDBY   = 4'hB;
  localparam logic [3:0] IDX_REV       = 4'hC;
  localparam logic [3:0] IDX_LAST      = IDX_REV;
  localparam logic [6:0] CODE_RESET    = 7'h00;

  localparam int         FAULT_OV_BIT  = 0;
  localparam int         FAULT_SH_LSB  = 2;
  localparam int         STANDBY_BIT   = 0;
  localparam int         TIMEOUT_BIT   = 7;
  localparam int         RW_BIT        = 0;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic [2:0] OUT_CHAN      = 3'h4;

  localparam int         CLK_PERIOD_NS = 10;
  localparam int         SPIKE_NS      = 50;
  localparam int         SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         FAULT_MIN_CYC = 2;

  typedef enum logic [2:0] {
    LS_ADDR   = 3'b000,
    LS_CMD    = 3'b001,
    LS_WDATA  = 3'b010,
    LS_RDATA  = 3'b011,
    LS_IGNORE = 3'b100
  } link_state_t;

  typedef enum logic [1:0] {
    EV_CMD = 2'b00,
    EV_WR  = 2'b01,
    EV_RD  = 2'b10
  } ev_kind_t;

endpackage

// ### core/line_filter.sv
`timescale 1ns/100ps
module line_filter #(
  parameter int               WIDTH  = 1,
  parameter int               STABLE = 2,
  parameter logic [WIDTH-1:0] INIT   = '1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  localparam int CW = $clog2(STABLE + 1);

  typedef struct packed {
    logic [WIDTH-1:0]         s1;
    logic [WIDTH-1:0]         s2;
    logic [WIDTH-1:0][CW-1:0] cnt;
    logic [WIDTH-1:0]         out;
  } filt_t;

  filt_t st_reg;
  filt_t st_next;

  // two-stage sync, then a new level must hold STABLE cycles
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.out[i]) begin
        st_next.cnt[i] = '0;
      end else if (st_reg.cnt[i] == CW'(STABLE - 1)) begin
        st_next.out[i] = st_reg.s2[i];
        st_next.cnt[i] = '0;
      end else begin
        st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{s1: INIT, s2: INIT, cnt: '0, out: INIT};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.out;
endmodule

// ### dv/i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // idle: both lines released, clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // start or repeated start, data falls while clock high
  task automatic start();
    sda_low = 1'b0;
    #625 scl = 1'b1;
    #625 sda_low = 1'b1;
    #625 scl = 1'b0;
    #625;
  endtask
  // stop, data rises while clock high
  task automatic stop();
    sda_low = 1'b1;
    #625 scl = 1'b1;
    #625 sda_low = 1'b0;
    #1250;
  endtask
  // one clock pulse, data moved only in the low phase
  task automatic bit_io(input logic b, output logic r);
    #250 sda_low = ~b;
    #1000 scl = 1'b1;
    #1250 r = sda;
    scl = 1'b0;
  endtask
  // eight bits then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_m, output logic [7:0] q,
                      output logic ack_s);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_m, ack_s);
  endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam logic [2:0] REV = 3'h5; // arbitrary value
  logic        clock, rstn, busy, adc_valid, ov_fault, sda_out, sda_oe, scl, m_low, standby;
  logic [2:0]  adc_chan;
  logic [7:0]  adc_data, wa, d0, d4, q;
  logic [3:0]  short_fault, sh;
  logic [6:0]  c1, c2, c3, c4, creg;
  logic [7:0]  code [5];
  wire  [34:0] all_codes = {creg, c4, c3, c2, c1};
  wire         sda = ~(m_low | (sda_oe & ~sda_out));
  int          seed, error_cnt, checks_done;

  i2c_master_model u_mst (.scl(scl), .sda_low(m_low), .sda(sda));

  led_i2c_slave #(.REV_CODE(REV), .SPIKE_CYC(1)) u_dut (
    .CLOCK(clock), .RSTN(rstn), .CE(1'b1), .SCL_CLK(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .BUSY(busy), .ADC_VALID(adc_valid),
    .ADC_CHAN(adc_chan), .ADC_DATA(adc_data), .SHORT_FAULT(short_fault),
    .OV_FAULT(ov_fault), .STRING1_CODE(c1), .STRING2_CODE(c2), .STRING3_CODE(c3),
    .STRING4_CODE(c4), .REGULATOR_CODE(creg), .LOW_POWER_STANDBY(standby));

  // system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [7:0] rd_exp(input logic [2:0] ch, input logic [7:0] d);
    return (ch == 3'h4) ? {1'b0, d[6:0]} : d;
  endfunction
  function automatic logic [7:0] fault_exp(input logic [3:0] s, input logic ov);
    return {2'b00, s, 1'b0, ov};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // master writes a byte, device ack level compared
  task automatic wbyte(input logic [7:0] d, input logic exp_nack);
    logic [7:0] r;
    logic       a;
    u_mst.xfer(d, 1'b1, r, a);
    check({7'h00, a}, {7'h00, exp_nack});
  endtask
  // master reads a byte and answers ack or nack
  task automatic rbyte(input logic nack, input logic [7:0] exp);
    logic a;
    u_mst.xfer(8'hFF, nack, q, a);
    check(q, exp);
  endtask
  task automatic adc(input logic [2:0] ch, input logic [7:0] d);
    @(negedge clock);
    adc_valid = 1'b1;
    adc_chan = ch;
    adc_data = d;
    @(negedge clock);
    adc_valid = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    seed = 37035;
    error_cnt = 0;
    checks_done = 0;
    rstn = 1'b0;
    busy = 1'b0;
    adc_valid = 1'b0;
    adc_chan = 3'h0;
    adc_data = 8'h00;
    short_fault = 4'h0;
    ov_fault = 1'b0;
    repeat (20) @(negedge clock);
    rstn = 1'b1;
    repeat (12) @(negedge clock);
    // foreign address refused
    wa = $random(seed);
    wa[0] = 1'b0;
    if (wa[7:1] == 7'h58) wa[7:1] = 7'h59;
    u_mst.start();
    wbyte(wa, 1'b1);
    u_mst.stop();
    // write: revision kept, pointer wraps, then all codes
    for (int i = 0; i < 5; i++) code[i] = $random(seed);
    u_mst.start();
    wbyte(led_if_pkg::ADDR_BYTE_WR, 1'b0);
    wbyte({4'h0, led_if_pkg::IDX_REV}, 1'b0);
    wbyte($random(seed), 1'b0);
    for (int i = 0; i < 5; i++) wbyte(code[i], 1'b0);
    u_mst.stop();
    for (int i = 0; i < 5; i++) check({1'b0, all_codes[7*i +: 7]}, {1'b0, code[i][6:0]});
    d0 = $random(seed);
    d0[7] = 1'b1;
    d4 = $random(seed);
    adc(3'h0, d0);
    adc(3'h4, d4);
    // out-of-map then busy command refused, pointer stays at 05h
    u_mst.start();
    wbyte(led_if_pkg::ADDR_BYTE_WR, 1'b0);
    wbyte(8'h0D, 1'b1);
    u_mst.stop();
    @(negedge clock);
    busy = 1'b1;
    u_mst.start();
    wbyte(led_if_pkg::ADDR_BYTE_WR, 1'b0);
    wbyte(8'h00, 1'b1);
    u_mst.stop();
    @(negedge clock);
    busy = 1'b0;
    u_mst.start();
    wbyte(led_if_pkg::ADDR_BYTE_RD, 1'b0);
    rbyte(1'b1, d0);
    u_mst.stop();
    // faults logged and sticky
    sh = $random(seed);
    sh[0] = 1'b1;
    @(negedge clock);
    short_fault = sh;
    ov_fault = 1'b1;
    repeat (10) @(negedge clock);
    short_fault = 4'h0;
    ov_fault = 1'b0;
    // read-only reading written and ignored, then read chain across the end of the map
    u_mst.start();
    wbyte(led_if_pkg::ADDR_BYTE_WR, 1'b0);
    wbyte({4'h0, led_if_pkg::IDX_RD_OUT} - 8'h01, 1'b0);
    wbyte(8'($random(seed)), 1'b0);
    u_mst.start();
    wbyte(led_if_pkg::ADDR_BYTE_RD, 1'b0);
    rbyte(1'b0, rd_exp(3'h4, d4));
    rbyte(1'b0, fault_exp(sh, 1'b1));
    rbyte(1'b0, 8'h00);
    rbyte(1'b0, {5'h00, REV});
    rbyte(1'b1, code[0] & 8'h7F);
    u_mst.stop();
    // fault register cleared by the completed read
    u_mst.start();
    wbyte(led_if_pkg::ADDR_BYTE_WR, 1'b0);
    wbyte({4'h0, led_if_pkg::IDX_FAULT}, 1'b0);
    u_mst.start();
    wbyte(led_if_pkg::ADDR_BYTE_RD, 1'b0);
    rbyte(1'b1, 8'h00);
    u_mst.stop();
    // standby set then cleared
    for (int i = 1; i >= 0; i--) begin
      u_mst.start();
      wbyte(led_if_pkg::ADDR_BYTE_WR, 1'b0);
      wbyte({4'h0, led_if_pkg::IDX_STANDBY}, 1'b0);
      wbyte(i[7:0], 1'b0);
      u_mst.stop();
      check({7'h00, standby}, i[7:0]);
    end
    tally_and_finish();
  end
endmodule
